/* File: core/mmd_map.svh */
// address map, field positions and wait counts of the memory map decoder
`ifndef MMD_MAP_SVH
`define MMD_MAP_SVH
`define MMD_ADDR_W        24
`define MMD_PEN_BIT       2
`define MMD_EXTENSION_RAM_LO       24'h00d000
`define MMD_EXTENSION_RAM_HI       24'h00e7ff
`define MMD_CAN_LO        24'h00ef00
`define MMD_CAN_HI        24'h00efff
`define MMD_EXTENDED_FUNC_REGS_LO       24'h00f000
`define MMD_EXTENDED_FUNC_REGS_HI       24'h00f1ff
`define MMD_INTERNAL_DUALPORT_RAM_LO       24'h00f600
`define MMD_INTERNAL_DUALPORT_RAM_HI       24'h00fdff
`define MMD_SFR_LO        24'h00fe00
`define MMD_SFR_HI        24'h00ffff
`define MMD_CAN_WAIT      2'h2
`define MMD_NO_WAIT       2'h0
`define MMD_SEG_ALL       8'hff
`define MMD_SEG_CAN       8'h0f
`define MMD_BE_WORD       2'h3
`define MMD_BE_LO         2'h1
`define MMD_BE_HI         2'h2
`endif

/* File: core/mmd_pkg.sv */
// types shared by the memory map decoder and its wait counter
package mmd_pkg;
  typedef enum logic [2:0] {
    TGT_EXT  = 3'h0,
    TGT_INTERNAL_DUALPORT_RAM = 3'h1,
    TGT_SFR  = 3'h2,
    TGT_EXTENDED_FUNC_REGS = 3'h3,
    TGT_EXTENSION_RAM = 3'h4,
    TGT_CAN  = 3'h5
  } mmd_target_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_WAIT = 2'h1
  } mmd_state_t;

  // one access as issued by the core
  typedef struct packed {
    logic [23:0] addr;
    logic        wr;
    logic        byte_acc;
    logic        bit_op;
    logic        stack_op;
  } mmd_req_t;

  // the steered access with the target's bus characteristics
  typedef struct packed {
    mmd_target_t tgt;
    logic [23:0] addr;
    logic        wr;
    logic [1:0]  byte_en;
    logic        demux;
    logic [1:0]  wait_st;
  } mmd_route_t;

  typedef struct packed {
    mmd_state_t state;
    mmd_route_t route;
    logic       route_vld;
    logic       done;
    logic       err;
    logic [7:0] seg_en;
  } mmd_dec_st_t;

  function automatic logic mmd_in(input logic [23:0] a, input logic [23:0] lo, input logic [23:0] hi);
    mmd_in = (a >= lo) && (a <= hi);
  endfunction
endpackage

/* File: core/mmd_wait_ctr.sv */
// wait-state down counter for slow on-chip targets
`timescale 1ns/1ps
module mmd_wait_ctr
  import mmd_pkg::*;
#(
  parameter int W = 2
) (
  input  wire logic         i_mclk,
  input  wire logic         i_rst_n,
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_count,
  output logic              o_last
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } mmd_ctr_st_t;

  mmd_ctr_st_t st_q;
  mmd_ctr_st_t st_d;

  generate
    if (W < 1) begin : g_chk
      $error("mmd_wait_ctr needs W of at least 1");
    end
  endgenerate

  // load wins over counting so a fresh access never inherits a stale count
  always_comb begin
    st_d = st_q;
    if (i_load) begin
      st_d.cnt = i_count;
    end else if (st_q.cnt != '0) begin
      st_d.cnt = st_q.cnt - W'(1);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // last wait cycle: the answer follows on the next edge
  assign o_last = (st_q.cnt == W'(1));
endmodule

/* File: core/mmd_decoder.sv */
// memory map decoder: steers core accesses to on-chip targets or the external bus
`timescale 1ns/1ps
`include "mmd_map.svh"
module mmd_decoder
  import mmd_pkg::*;
#(
  parameter int ADDR_W = `MMD_ADDR_W
) (
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  input  wire logic        i_req,
  input  wire mmd_req_t    i_acc,
  input  wire logic [15:0] i_system_config_reg,
  output logic             o_busy,
  output logic             o_route_vld,
  output mmd_route_t       o_route,
  output logic             o_done,
  output logic             o_err,
  output logic [7:0]       o_seg_line_en
);
  // =====================================================================
  // checks and declarations
  generate
    if (ADDR_W != `MMD_ADDR_W) begin : g_chk
      $error("mmd_decoder serves a 24-bit address space only");
    end
  endgenerate

  mmd_dec_st_t st_q;
  mmd_dec_st_t st_d;
  logic        periph_bus_enable;
  logic        taken;
  logic        wait_last;
  logic        hit_extension_ram;
  logic        hit_can;
  logic        hit_internal_dualport_ram;
  logic        hit_sfr;
  logic        hit_extended_func_regs;
  mmd_route_t  rt;

  // a request is only taken while no can access is still counting its wait states
  assign periph_bus_enable = i_system_config_reg[`MMD_PEN_BIT];
  assign taken             = i_req && (st_q.state == ST_IDLE);

  // =====================================================================
  // range decode
  // one enable bit gates both extension ram and the can window together
  always_comb begin
    hit_extension_ram = periph_bus_enable && mmd_in(i_acc.addr, `MMD_EXTENSION_RAM_LO, `MMD_EXTENSION_RAM_HI);
    hit_can  = periph_bus_enable && mmd_in(i_acc.addr, `MMD_CAN_LO, `MMD_CAN_HI);
    hit_internal_dualport_ram = mmd_in(i_acc.addr, `MMD_INTERNAL_DUALPORT_RAM_LO, `MMD_INTERNAL_DUALPORT_RAM_HI);
    hit_sfr  = mmd_in(i_acc.addr, `MMD_SFR_LO, `MMD_SFR_HI);
    hit_extended_func_regs = mmd_in(i_acc.addr, `MMD_EXTENDED_FUNC_REGS_LO, `MMD_EXTENDED_FUNC_REGS_HI);
  end

  // target and bus characteristics of the access being taken
  always_comb begin
    rt         = '0;
    rt.addr    = i_acc.addr;
    rt.wr      = i_acc.wr;
    // byte lane from address bit 0, word takes both lanes
    rt.byte_en = i_acc.byte_acc ? (i_acc.addr[0] ? `MMD_BE_HI : `MMD_BE_LO) : `MMD_BE_WORD;
    rt.wait_st = `MMD_NO_WAIT;
    rt.demux   = 1'b0;
    if (hit_extension_ram) begin
      rt.tgt   = TGT_EXTENSION_RAM;
      rt.demux = 1'b1;
    end else if (hit_can) begin
      rt.tgt     = TGT_CAN;
      rt.demux   = 1'b1;
      rt.wait_st = `MMD_CAN_WAIT;
    end else if (hit_internal_dualport_ram) begin
      rt.tgt = TGT_INTERNAL_DUALPORT_RAM; // stack and register banks are legal here
    end else if (hit_sfr) begin
      rt.tgt = TGT_SFR;
    end else if (hit_extended_func_regs) begin
      rt.tgt = TGT_EXTENDED_FUNC_REGS;
    end else begin
      // the external interface picks its own chip select and bus setting
      rt.tgt = TGT_EXT;
    end
  end

  // =====================================================================
  // wait-state counter, loaded only for slow targets
  mmd_wait_ctr #(
    .W (2)
  ) i_mmd_wait_ctr (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_load  (taken && hit_can),
    .i_count (`MMD_CAN_WAIT),
    .o_last  (wait_last)
  );

  // =====================================================================
  // next state
  always_comb begin
    st_d           = st_q;
    st_d.route_vld = 1'b0;
    st_d.done      = 1'b0;
    st_d.err       = 1'b0;
    // can shares port lines, so only the low segment lines stay external
    st_d.seg_en    = periph_bus_enable ? `MMD_SEG_CAN : `MMD_SEG_ALL;
    case (st_q.state)
      ST_IDLE: begin
        if (taken) begin
          if (hit_extension_ram && (i_acc.bit_op || i_acc.stack_op)) begin
            // refused rather than silently mis-stored
            st_d.err = 1'b1;
          end else begin
            st_d.route     = rt;
            st_d.route_vld = 1'b1;
            if (hit_can) begin
              st_d.state = ST_WAIT;
            end else begin
              st_d.done = 1'b1;
            end
          end
        end
      end
      ST_WAIT: begin
        if (wait_last) begin
          st_d.state = ST_IDLE;
          st_d.done  = 1'b1;
        end
      end
      default: begin
        st_d.state = ST_IDLE;
      end
    endcase
  end

  // synchronous reset; segment lines come up all driven until the enable is seen
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      st_q        <= '0;
      st_q.seg_en <= `MMD_SEG_ALL;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs read the state register directly; only the wait state has bit 0 set
  assign o_busy        = st_q.state[0];
  assign o_route_vld   = st_q.route_vld;
  assign o_route       = st_q.route;
  assign o_done        = st_q.done;
  assign o_err         = st_q.err;
  assign o_seg_line_en = st_q.seg_en;

  // =====================================================================
  // assertions
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  AST_EXTENSION_RAM_ROUTE: assert property (taken && hit_extension_ram && !i_acc.bit_op && !i_acc.stack_op
    |=> o_route_vld && o_route.tgt == TGT_EXTENSION_RAM && o_route.addr == $past(i_acc.addr))
    else $error("extension ram access not routed there");
  AST_EXTENSION_RAM_OFF: assert property (taken && !periph_bus_enable
    && mmd_in(i_acc.addr, `MMD_EXTENSION_RAM_LO, `MMD_EXTENSION_RAM_HI) |=> o_route_vld && o_route.tgt == TGT_EXT)
    else $error("disabled extension ram range not sent external");
  AST_EXTENSION_RAM_NOWAIT: assert property (o_route_vld && o_route.tgt == TGT_EXTENSION_RAM
    |-> o_done && o_route.demux && o_route.wait_st == `MMD_NO_WAIT && !o_busy)
    else $error("extension ram access not zero wait");
  AST_EXTENSION_RAM_NOBIT: assert property (taken && hit_extension_ram && (i_acc.bit_op || i_acc.stack_op)
    |=> o_err && !o_route_vld && !o_done)
    else $error("bit or stack access to extension ram not refused");
  AST_CAN_ROUTE: assert property (taken && hit_can
    |=> o_route_vld && o_route.tgt == TGT_CAN && o_route.demux)
    else $error("can window access not routed to can");
  AST_CAN_WAIT: assert property (o_route_vld && o_route.tgt == TGT_CAN
    |-> !o_done ##1 (!o_done && o_busy) ##1 (o_done && !o_busy))
    else $error("can access not exactly two wait states");
  AST_SEG_LINES: assert property (periph_bus_enable |=> o_seg_line_en == `MMD_SEG_CAN)
    else $error("segment lines not limited while can is in use");
  AST_SEG_ALL: assert property (!periph_bus_enable |=> o_seg_line_en == `MMD_SEG_ALL)
    else $error("segment lines limited while can is unused");
  AST_INTERNAL_DUALPORT_RAM: assert property (taken && hit_internal_dualport_ram && !hit_extension_ram && !hit_can
    |=> o_route_vld && o_route.tgt == TGT_INTERNAL_DUALPORT_RAM && !o_err)
    else $error("internal ram access not routed there");
  AST_SFR: assert property (taken && (hit_sfr || hit_extended_func_regs)
    |=> o_route_vld && (o_route.tgt == TGT_SFR || o_route.tgt == TGT_EXTENDED_FUNC_REGS))
    else $error("function register access misrouted");
  AST_FALLBACK: assert property (taken && !hit_extension_ram && !hit_can && !hit_internal_dualport_ram
    && !hit_sfr && !hit_extended_func_regs |=> o_route_vld && o_route.tgt == TGT_EXT && o_done)
    else $error("unmapped access not sent to external bus");
  AST_BYTE_LANE: assert property (taken && i_acc.byte_acc
    && !(hit_extension_ram && (i_acc.bit_op || i_acc.stack_op))
    |=> o_route.byte_en == ($past(i_acc.addr[0]) ? `MMD_BE_HI : `MMD_BE_LO))
    else $error("byte access drove the wrong lane");
  AST_WORD_LANE: assert property (taken && !i_acc.byte_acc
    && !(hit_extension_ram && (i_acc.bit_op || i_acc.stack_op))
    |=> o_route.byte_en == `MMD_BE_WORD)
    else $error("word access did not drive both lanes");
  // a request raised during the wait cycles is ignored, never queued behind the can access
  AST_BUSY_HOLD: assert property (o_busy |=> !o_route_vld && !o_err)
    else $error("access taken while can access still waiting");
  // refusal only ever comes from the extension ram window
  AST_ERR_SRC: assert property (taken && !hit_extension_ram |=> !o_err)
    else $error("access outside extension ram refused");

  // main scenarios: zero-wait, waited, refused and external accesses
  COV_EXTENSION_RAM: cover property (o_route_vld && o_route.tgt == TGT_EXTENSION_RAM);
  COV_CAN:  cover property (o_route_vld && o_route.tgt == TGT_CAN ##2 o_done);
  COV_ERR:  cover property (o_err);
  COV_EXT:  cover property (o_route_vld && o_route.tgt == TGT_EXT);
endmodule

/* File: testbench/mmd_core_model.sv */
// core-side model that presents one access at a time to the decoder
`timescale 1ns/1ps
module mmd_core_model
  import mmd_pkg::*;
(
  input  wire logic i_mclk,
  input  wire logic i_busy,
  output logic      o_req,
  output mmd_req_t  o_acc
);
  // ==========================================
  // access issue
  initial begin
    o_req = 1'b0;
    o_acc = '0;
  end
  // held until an edge with busy low takes it; released lines never keep the old address
  task automatic issue(input mmd_req_t a);
    @(posedge i_mclk);
    o_req <= 1'b1;
    o_acc <= a;
    @(posedge i_mclk);
    while (i_busy === 1'b1) @(posedge i_mclk);
    o_req <= 1'b0;
    o_acc <= ~a;
  endtask
endmodule

/* File: testbench/mmd_decoder_tb.sv */
// self-checking bench for the memory map decoder
`timescale 1ns/1ps
`include "mmd_map.svh"
module mmd_decoder_tb
  import mmd_pkg::*;
;
  logic        mclk;
  logic        rst_n;
  logic        req;
  mmd_req_t    acc_w;
  logic [15:0] cfg;
  logic        busy;
  logic        rvld;
  mmd_route_t  route;
  logic        done;
  logic        err;
  logic [7:0]  seg;
  int          error_cnt = 0;
  int          checked = 0;

  // ==========================================
  // design and core model
  mmd_decoder i_mmd_decoder (.i_mclk(mclk), .i_rst_n(rst_n), .i_req(req), .i_acc(acc_w),
    .i_system_config_reg(cfg), .o_busy(busy), .o_route_vld(rvld), .o_route(route),
    .o_done(done), .o_err(err), .o_seg_line_en(seg));
  mmd_core_model i_mmd_core_model (.i_mclk(mclk), .i_busy(busy), .o_req(req), .o_acc(acc_w));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one access, then the route and the completion timing
  task automatic acc(input logic [23:0] a, input logic w, b, bo, so, input mmd_target_t t,
                     input logic [1:0] ws, input logic refuse);
    mmd_req_t r;
    int       n;
    r = '{addr: a, wr: w, byte_acc: b, bit_op: bo, stack_op: so};
    n = 0;
    i_mmd_core_model.issue(r);
    #1;
    while (rvld !== 1'b1 && err !== 1'b1 && n < 4) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk("refused", refuse, err);
    chk("route valid", !refuse, rvld);
    if (!refuse) begin
      chk("target", t, route.tgt);
      chk("address", a, route.addr);
      chk("write", w, route.wr);
      chk("lanes", b ? (a[0] ? `MMD_BE_HI : `MMD_BE_LO) : `MMD_BE_WORD, route.byte_en);
      chk("wait states", ws, route.wait_st);
      if (t == TGT_EXTENSION_RAM || t == TGT_CAN) chk("demux", 1'b1, route.demux);
      chk("done", ws == 2'h0, done);
      if (ws != 2'h0) begin
        chk("busy", 1'b1, busy);
        @(posedge mclk);
        #1;
        chk("early done", 1'b0, done);
        @(posedge mclk);
        #1;
        chk("late done", 1'b1, done);
        chk("busy end", 1'b0, busy);
      end
    end else chk("done", 1'b0, done);
  endtask

  // other config bits flipped so only the enable bit may matter
  task automatic set_en(input logic e);
    @(posedge mclk);
    cfg <= e ? 16'h0004 : 16'hfffb;
    @(posedge mclk);
    @(posedge mclk);
    #1;
    chk("segment lines", e ? `MMD_SEG_CAN : `MMD_SEG_ALL, seg);
  endtask

  task automatic t_reset();
    @(posedge mclk);
    #1;
    chk("reset outputs", 37'h0, {busy, rvld, done, err, route});
    chk("reset segments", `MMD_SEG_ALL, seg);
  endtask

  task automatic t_extension_ram();
    set_en(1'b1);
    acc(24'h00d000, 1'b1, 1'b1, 1'b0, 1'b0, TGT_EXTENSION_RAM, `MMD_NO_WAIT, 1'b0);
    acc(24'h00e7ff, 1'b0, 1'b1, 1'b0, 1'b0, TGT_EXTENSION_RAM, `MMD_NO_WAIT, 1'b0);
    acc(24'h00e7fe, 1'b0, 1'b0, 1'b0, 1'b0, TGT_EXTENSION_RAM, `MMD_NO_WAIT, 1'b0);
    acc(24'h00cfff, 1'b0, 1'b0, 1'b0, 1'b0, TGT_EXT, `MMD_NO_WAIT, 1'b0);
    acc(24'h00e800, 1'b0, 1'b0, 1'b0, 1'b0, TGT_EXT, `MMD_NO_WAIT, 1'b0);
    acc(24'h00d010, 1'b0, 1'b0, 1'b1, 1'b0, TGT_EXTENSION_RAM, `MMD_NO_WAIT, 1'b1);
    acc(24'h00d010, 1'b1, 1'b0, 1'b0, 1'b1, TGT_EXTENSION_RAM, `MMD_NO_WAIT, 1'b1);
    set_en(1'b0);
    acc(24'h00d010, 1'b0, 1'b0, 1'b1, 1'b0, TGT_EXT, `MMD_NO_WAIT, 1'b0);
  endtask

  task automatic t_can();
    set_en(1'b1);
    acc(24'h00ef00, 1'b0, 1'b0, 1'b0, 1'b0, TGT_CAN, `MMD_CAN_WAIT, 1'b0);
    acc(24'h00efff, 1'b1, 1'b1, 1'b0, 1'b0, TGT_CAN, `MMD_CAN_WAIT, 1'b0);
    set_en(1'b0);
    acc(24'h00ef00, 1'b0, 1'b0, 1'b0, 1'b0, TGT_EXT, `MMD_NO_WAIT, 1'b0);
  endtask

  task automatic t_map();
    acc(24'h00f600, 1'b0, 1'b0, 1'b0, 1'b1, TGT_INTERNAL_DUALPORT_RAM, `MMD_NO_WAIT, 1'b0);
    acc(24'h00fdff, 1'b1, 1'b1, 1'b1, 1'b0, TGT_INTERNAL_DUALPORT_RAM, `MMD_NO_WAIT, 1'b0);
    acc(24'h00fe00, 1'b0, 1'b0, 1'b0, 1'b0, TGT_SFR, `MMD_NO_WAIT, 1'b0);
    acc(24'h00f1ff, 1'b0, 1'b1, 1'b0, 1'b0, TGT_EXTENDED_FUNC_REGS, `MMD_NO_WAIT, 1'b0);
    acc(24'h123456, 1'b1, 1'b0, 1'b0, 1'b0, TGT_EXT, `MMD_NO_WAIT, 1'b0);
    acc(24'hffffff, 1'b0, 1'b1, 1'b0, 1'b0, TGT_EXT, `MMD_NO_WAIT, 1'b0);
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ==========================================
  // main sequence and watchdog (whole run is about 70 cycles)
  initial begin
    rst_n = 1'b0;
    cfg = 16'h0000;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_extension_ram();
    t_can();
    t_map();
    finish_test();
  end

  initial begin
    repeat (3000) @(posedge mclk);
    error_cnt++;
    finish_test();
  end
endmodule
